// [agi_defs.svh]
// constants for the converter global interrupt and scan select block
// assumes a 32-bit axi4-lite register bus and a single 100 MHz clock
// Contract
// - enabled ready rising edge raises global interrupt
// - disabled input never feeds global interrupt
// - global enables leave per-input interrupts alone
// - global interrupt gated by system enable bit
// - high enable register holds inputs 32-44
// - scan select bit includes or skips input
// - high scan register holds inputs 32-44
// - alternate routing only for dedicated-hold inputs
// - alternate routing changes only physical source
// - all bits reset zero, unimplemented read zero
// - ready set on result, cleared on data read
`ifndef AGI_DEFS_SVH
`define AGI_DEFS_SVH
`define AGI_NUM_INPUTS      45
`define AGI_HIGH_BITS       13
`define AGI_NUM_ALT         5
`define AGI_OFS_GIE_LOW     8'h00
`define AGI_OFS_GIE_HIGH    8'h04
`define AGI_OFS_SCAN_LOW    8'h08
`define AGI_OFS_SCAN_HIGH   8'h0C
`define AGI_OFS_READY_LOW   8'h10
`define AGI_OFS_READY_HIGH  8'h14
`define AGI_OFS_ALT_SEL     8'h18
`define AGI_OFS_GIRQ_STAT   8'h1C
`define AGI_OFS_SYS_IEN     8'h20
`define AGI_RESET_VALUE     32'h0000_0000
`define AGI_RESP_OKAY       2'h0
`define AGI_RESP_SLVERR     2'h2
`endif

// [agi_pkg.sv]
// types shared by the global interrupt and scan select block
// assumes agi_defs.svh is compiled alongside
package agi_pkg;
    typedef logic [44:0] agi_vec_t;
    typedef logic [1:0]  agi_alt_t;
    typedef enum logic [1:0] {
        AGI_ALT_DEFAULT,
        AGI_ALT_SECOND,
        AGI_ALT_RSV2,
        AGI_ALT_RSV3
    } agi_alt_sel_t;
endpackage : agi_pkg

// [agi_ready_flags.sv]
// per-input data-ready flags and their rising-edge events
// assumes the converter core pulses result_valid and data_read on aclk
`timescale 1ns/1ps
`include "agi_defs.svh"
module agi_ready_flags (
    // clock and reset
    input  wire logic            aclk,
    input  wire logic            aresetn,
    // converter side
    input  wire agi_pkg::agi_vec_t result_valid,
    input  wire agi_pkg::agi_vec_t data_read,
    // flag state
    output agi_pkg::agi_vec_t    ready_q,
    output agi_pkg::agi_vec_t    rise_event
);
    agi_pkg::agi_vec_t ready_d;

    // one flag per input; a new result wins over a read in the same cycle
    genvar i;
    for (i = 0; i < `AGI_NUM_INPUTS; i++) begin : g_flag
        always_comb begin
            ready_d[i] = result_valid[i] | (ready_q[i] & ~data_read[i]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ready_q <= '0;
        end else begin
            ready_q <= ready_d;
        end
    end

    // 0 to 1 transition of each flag, seen the cycle it happens
    assign rise_event = ready_d & ~ready_q;
endmodule : agi_ready_flags

// [agi_alt_route.sv]
// alternate physical input routing for dedicated sample-and-hold inputs
// assumes the analog mux reads route_alt; data indices stay unchanged
`timescale 1ns/1ps
`include "agi_defs.svh"
module agi_alt_route (
    // control
    input  wire logic [9:0] alt_field,
    // analog mux steering
    output logic [4:0]      route_alt
);
    // only codes 01 pick the alternate pin; reserved codes keep default
    genvar i;
    for (i = 0; i < `AGI_NUM_ALT; i++) begin : g_alt
        assign route_alt[i] = (agi_pkg::agi_alt_sel_t'(alt_field[2*i +: 2])
                              == agi_pkg::AGI_ALT_SECOND);
    end
endmodule : agi_alt_route

// [agi_global_irq.sv]
// global converter interrupt, scan select and routing registers
// assumes an axi4-lite master on aclk and a converter core that
// reports results and data-register reads as one-cycle pulses
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "agi_defs.svh"
module agi_global_irq (
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // axi4-lite write address
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    // axi4-lite write response
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    // axi4-lite read data
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // converter core
    input  wire agi_pkg::agi_vec_t result_valid,
    input  wire agi_pkg::agi_vec_t data_read,
    output agi_pkg::agi_vec_t     scan_select_bit,
    output logic [4:0]            route_alt,
    // interrupt outputs
    output agi_pkg::agi_vec_t     input_irq,
    output logic                  global_irq
);
    // register state
    agi_pkg::agi_vec_t gie_q;
    agi_pkg::agi_vec_t scan_q;
    agi_pkg::agi_vec_t ien_q;
    logic [9:0]        alt_q;
    logic              sys_gie_q;
    logic              girq_q;
    logic              girq_d;
    agi_pkg::agi_vec_t ready_q;
    agi_pkg::agi_vec_t rise_event;

    // bus state
    logic        aw_held_q;
    logic [7:0]  aw_addr_q;
    logic        w_held_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_go;
    logic        wr_hit;
    logic        clr_girq;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic [31:0] wmask;

    agi_ready_flags u_flags (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .result_valid (result_valid),
        .data_read    (data_read),
        .ready_q      (ready_q),
        .rise_event   (rise_event)
    );

    agi_alt_route u_route (
        .alt_field (alt_q),
        .route_alt (route_alt)
    );

    // write channels are taken independently, in either order
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign wr_go         = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            w_data_q <= `AGI_RESET_VALUE;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_q <= 1'b0;
        end
    end

    // byte-lane mask from the strobes
    genvar b;
    for (b = 0; b < 4; b++) begin : g_lane
        assign wmask[8*b +: 8] = {8{w_strb_q[b]}};
    end

    always_comb begin
        case (aw_addr_q)
            `AGI_OFS_GIE_LOW, `AGI_OFS_GIE_HIGH, `AGI_OFS_SCAN_LOW,
            `AGI_OFS_SCAN_HIGH, `AGI_OFS_ALT_SEL, `AGI_OFS_GIRQ_STAT,
            `AGI_OFS_SYS_IEN: wr_hit = 1'b1;
            default:          wr_hit = 1'b0;
        endcase
    end

    // write response; unmapped offsets answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `AGI_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `AGI_RESP_OKAY : `AGI_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // enable and select registers; only implemented bits are stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gie_q  <= '0;
            scan_q <= '0;
            ien_q  <= '0;
            alt_q  <= 10'h000;
        end else if (wr_go) begin
            case (aw_addr_q)
                `AGI_OFS_GIE_LOW:   gie_q[31:0]   <= (gie_q[31:0] & ~wmask)
                                                    | (w_data_q & wmask);
                `AGI_OFS_GIE_HIGH:  gie_q[44:32]  <= (gie_q[44:32] & ~wmask[12:0])
                                                    | (w_data_q[12:0] & wmask[12:0]);
                `AGI_OFS_SCAN_LOW:  scan_q[31:0]  <= (scan_q[31:0] & ~wmask)
                                                    | (w_data_q & wmask);
                `AGI_OFS_SCAN_HIGH: scan_q[44:32] <= (scan_q[44:32] & ~wmask[12:0])
                                                    | (w_data_q[12:0] & wmask[12:0]);
                `AGI_OFS_ALT_SEL:   alt_q         <= (alt_q & ~wmask[25:16])
                                                    | (w_data_q[25:16] & wmask[25:16]);
                `AGI_OFS_SYS_IEN:   ien_q[31:0]   <= (ien_q[31:0] & ~wmask)
                                                    | (w_data_q & wmask);
                // upper per-input system enables share the status word, bits 12:0
                `AGI_OFS_GIRQ_STAT: ien_q[44:32]  <= (ien_q[44:32] & ~wmask[12:0])
                                                    | (w_data_q[12:0] & wmask[12:0]);
                default: ;
            endcase
        end
    end

    // system enable for the global line sits in bit 31 of status word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_gie_q <= 1'b0;
        end else if (wr_go && aw_addr_q == `AGI_OFS_GIRQ_STAT && w_strb_q[3]) begin
            sys_gie_q <= w_data_q[31];
        end
    end

    // write one to bit 16 of the status word clears the pending flag
    assign clr_girq = wr_go && aw_addr_q == `AGI_OFS_GIRQ_STAT
                      && w_strb_q[2] && w_data_q[16];

    // sticky OR of enabled rising events; a new event beats the clear
    always_comb begin
        girq_d = girq_q;
        if (clr_girq) begin
            girq_d = 1'b0;
        end
        if (|(rise_event & gie_q)) begin
            girq_d = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            girq_q <= 1'b0;
        end else begin
            girq_q <= girq_d;
        end
    end

    // outputs toward the interrupt controller and the scan sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            global_irq      <= 1'b0;
            input_irq       <= '0;
            scan_select_bit <= '0;
        end else begin
            global_irq      <= girq_q & sys_gie_q;
            input_irq       <= ready_q & ien_q;
            scan_select_bit <= scan_q;
        end
    end

    // read mux; unimplemented bits read zero
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = `AGI_RESET_VALUE;
        case (s_axi_araddr)
            `AGI_OFS_GIE_LOW:    rd_word = gie_q[31:0];
            `AGI_OFS_GIE_HIGH:   rd_word = {19'h0, gie_q[44:32]};
            `AGI_OFS_SCAN_LOW:   rd_word = scan_q[31:0];
            `AGI_OFS_SCAN_HIGH:  rd_word = {19'h0, scan_q[44:32]};
            `AGI_OFS_READY_LOW:  rd_word = ready_q[31:0];
            `AGI_OFS_READY_HIGH: rd_word = {19'h0, ready_q[44:32]};
            `AGI_OFS_ALT_SEL:    rd_word = {6'h0, alt_q, 16'h0};
            `AGI_OFS_GIRQ_STAT:  rd_word = {sys_gie_q, 14'h0, girq_q, 3'h0, ien_q[44:32]};
            `AGI_OFS_SYS_IEN:    rd_word = ien_q[31:0];
            default:             rd_hit  = 1'b0;
        endcase
    end

    // read channel: one read at a time, data registered
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= `AGI_RESET_VALUE;
            s_axi_rresp  <= `AGI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? `AGI_RESP_OKAY : `AGI_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : agi_global_irq

// [agi_global_irq_properties.sv]
// concurrent checks on the ports of the global interrupt block
// assumes one aclk domain and a bind from the testbench top file
`timescale 1ns/1ps
module agi_checker (
    // clock and reset
    input wire logic              aclk, aresetn,
    // bus handshakes
    input wire logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic              s_axi_bvalid, s_axi_bready,
    input wire logic [7:0]        s_axi_araddr,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp, s_axi_bresp,
    // converter and interrupt side
    input wire agi_pkg::agi_vec_t result_valid, input_irq, scan_select_bit,
    input wire logic [4:0]        route_alt,
    input wire logic              global_irq
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // read steps: address taken, then an unmapped one
    sequence s_ar_taken; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_bad_ar; s_ar_taken ##0 (s_axi_araddr > 8'h20); endsequence
    a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_bad_read_zero: assert property (s_bad_ar |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not zero with error");
    a_reset_zero: assert property ($rose(aresetn) |-> !global_irq && input_irq == 45'h0
        && scan_select_bit == 45'h0 && route_alt == 5'h00 && !s_axi_rvalid && !s_axi_bvalid)
        else $error("outputs not clear after reset");
    a_girq_cause: assert property ($rose(global_irq) |-> $past(result_valid, 2) != 45'h0
        || $past(result_valid, 3) != 45'h0 || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("global interrupt rose without cause");
    a_girq_sticky: assert property ($fell(global_irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("global interrupt dropped without software");
    a_scan_by_write: assert property (!$stable(scan_select_bit) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("scan select changed without a write");
    a_route_by_write: assert property (!$stable(route_alt) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("routing changed without a write");
endmodule : agi_checker

// [agi_core_model.sv]
// converter core stand-in: result and data-read pulses
// assumes the caller is just past a rising edge of aclk
`timescale 1ns/1ps
module agi_core_model (
    // clock
    input wire logic          aclk,
    // pulses toward the block
    output agi_pkg::agi_vec_t result_valid,
    output agi_pkg::agi_vec_t data_read
);
    // idle with no events pending
    initial begin
        result_valid = 45'h0;
        data_read = 45'h0;
    end
    // one-cycle pulse on a single input
    task automatic pulse(input int idx, input logic rdd);
        @(posedge aclk);
        if (rdd) data_read <= 45'h1 << idx;
        else result_valid <= 45'h1 << idx;
        @(posedge aclk);
        data_read <= 45'h0;
        result_valid <= 45'h0;
    endtask : pulse
endmodule : agi_core_model

// [agi_global_irq_tb.sv]
// self-checking bench for the global interrupt and scan select block
// assumes agi_pkg, the design and agi_core_model are compiled first
`timescale 1ns/1ps
module agi_global_irq_tb;
    logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0;
    logic arv = 1'b0, rready = 1'b0, awr, wrdy, bv, arr, rv, gi;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat, m [0:8];
    logic [1:0] br, rr;
    logic [3:0] ws = 4'hF;
    logic [4:0] ra;
    agi_pkg::agi_vec_t res, drd, ssb, iirq;
    int miscompares = 0, n_compared = 0;
    // free-running 100 MHz clock
    always #5 aclk = ~aclk;
    agi_core_model agi_core_model_i (.aclk(aclk), .result_valid(res), .data_read(drd));
    agi_global_irq agi_global_irq_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bready), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready),
        .result_valid(res), .data_read(drd), .scan_select_bit(ssb), .route_alt(ra),
        .input_irq(iirq), .global_irq(gi));
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim
    task automatic chk(input string n, input logic [44:0] e, input logic [44:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // write: address and data offered together, bready once bvalid is seen
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
        while (awv || wv || !bv) begin
            @(posedge aclk);
            if (awr && awv) awv <= 1'b0;
            if (wrdy && wv) wv <= 1'b0;
            if (bv) bready <= 1'b1;
        end
        @(posedge aclk);
        r = br;
        bready <= 1'b0;
    endtask : bus_wr
    // read: late rready so the slave must hold its answer
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        ara <= a; arv <= 1'b1;
        while (arv || !rv) begin
            @(posedge aclk);
            if (arr && arv) arv <= 1'b0;
            if (rv) rready <= 1'b1;
        end
        @(posedge aclk);
        d = rdat; r = rr;
        rready <= 1'b0;
    endtask : bus_rd
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        bus_rd(a, d, r);
        chk("rdata", e, d);
        chk("rresp", 2'h0, r);
    endtask : rchk
    // implemented bits of each writable word except the status word 1C
    function automatic logic [31:0] msk(input logic [7:0] a);
        case (a)
            8'h04, 8'h0C: msk = 32'h0000_1FFF;
            8'h18: msk = 32'h03FF_0000;
            default: msk = 32'hFFFF_FFFF;
        endcase
    endfunction : msk
    // hang guard, far above the few hundred cycles the tests need
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
    // main sequence
    initial begin
        logic [7:0] aq [$] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20, 8'h18, 8'h18, 8'h18};
        logic [31:0] v;
        logic [1:0] r;
        logic [44:0] rdy;
        logic [4:0] e5;
        int k;
        k = $urandom(74);
        rdy = 45'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (m[i]) rchk(8'(i * 4), 32'h0);
        foreach (m[i]) m[i] = 32'h0;
        $display("test reset values done");
        foreach (aq[i]) begin
            v = (i == 6) ? 32'h0155_0000 : $urandom;
            bus_wr(aq[i], v, r);
            m[aq[i] >> 2] = v & msk(aq[i]);
            rchk(aq[i], m[aq[i] >> 2]);
            chk("scan", {m[3][12:0], m[2]}, ssb);
            for (int j = 0; j < 5; j++) e5[j] = (m[6][16 + 2 * j +: 2] == 2'b01);
            chk("route", e5, ra);
        end
        // low byte lane only: upper scan bits must keep their value
        ws <= 4'h1;
        bus_wr(8'h08, 32'hFFFF_FFFF, r);
        ws <= 4'hF;
        m[2][7:0] = 8'hFF;
        rchk(8'h08, m[2]);
        chk("scan", {m[3][12:0], m[2]}, ssb);
        $display("test registers done");
        bus_wr(8'h00, 32'h0, r);
        bus_wr(8'h04, 32'h0000_1000, r);
        bus_wr(8'h20, 32'h0, r);
        bus_wr(8'h1C, 32'h8001_0000, r);
        k = $urandom_range(43, 0);
        agi_core_model_i.pulse(k, 1'b0);
        rdy[k] = 1'b1;
        repeat (4) @(posedge aclk);
        chk("girq", 1'b0, gi);
        chk("iirq", 45'h0, iirq);
        rchk(8'h10, rdy[31:0]);
        rchk(8'h14, {19'h0, rdy[44:32]});
        agi_core_model_i.pulse(44, 1'b0);
        rdy[44] = 1'b1;
        repeat (4) @(posedge aclk);
        chk("girq", 1'b1, gi);
        rchk(8'h1C, 32'h8001_0000);
        agi_core_model_i.pulse(44, 1'b1);
        rdy[44] = 1'b0;
        rchk(8'h14, {19'h0, rdy[44:32]});
        chk("girq", 1'b1, gi);
        bus_wr(8'h1C, 32'h0001_0000, r);
        repeat (2) @(posedge aclk);
        chk("girq", 1'b0, gi);
        agi_core_model_i.pulse(44, 1'b0);
        rdy[44] = 1'b1;
        repeat (4) @(posedge aclk);
        chk("girq", 1'b0, gi);
        rchk(8'h1C, 32'h0001_0000);
        bus_wr(8'h1C, 32'h8000_0000, r);
        repeat (2) @(posedge aclk);
        chk("girq", 1'b1, gi);
        $display("test global interrupt done");
        bus_wr(8'h04, 32'h0, r);
        bus_wr(8'h1C, 32'h8001_1FFF, r);
        bus_wr(8'h20, 32'hFFFF_FFFF, r);
        k = $urandom_range(43, 0);
        agi_core_model_i.pulse(k, 1'b0);
        rdy[k] = 1'b1;
        repeat (4) @(posedge aclk);
        chk("iirq", rdy, iirq);
        chk("girq", 1'b0, gi);
        $display("test input interrupts done");
        bus_wr(8'h24, $urandom, r);
        chk("bresp", 2'h2, r);
        bus_rd(8'h3C, v, r);
        chk("rdata", 32'h0, v);
        chk("rresp", 2'h2, r);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(8'h08, 32'h0);
        chk("scan", 45'h0, ssb);
        chk("iirq", 45'h0, iirq);
        $display("test unmapped and reset done");
        end_sim();
    end
endmodule : agi_global_irq_tb
bind agi_global_irq agi_checker agi_checker_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_bresp(s_axi_bresp), .result_valid(result_valid), .input_irq(input_irq),
    .scan_select_bit(scan_select_bit), .route_alt(route_alt), .global_irq(global_irq));
